// ---- dv/tb.sv ----
`timescale 1ns/10ps
`include "ufb_cfg.svh"
module tb;
	import ufb_pkg::*;
	logic        ref_clk, reset_n, awvalid, awready, wvalid, wready;
	logic        bvalid, bready, arvalid, arready, rvalid, rready;
	logic        rxd, txd, irq;
	logic [7:0]  awaddr, araddr, p_byte;
	logic [31:0] wdata, rdata, rv;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rr;
	logic [15:0] bit_clks;
	int          p_got, p_low, num_errors, checks, cyc;

	ufb_top u_ufb_top (.ref_clk, .reset_n, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rxd, .txd,
		.irq);
	ufb_peer u_peer (.ref_clk, .txd, .bit_clks, .rxd, .last_byte(p_byte),
		.got(p_got), .low_ns(p_low));

	// one clock for bus and line alike, 50 ns
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// hang guard; the whole run needs well under half of this
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// readies are combinational, so the negedge value is the edge value
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic at, wt, bt;
		bt = 1'b0;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!bt) begin
			@(negedge ref_clk);
			at = awvalid & awready;
			wt = wvalid & wready;
			bt = bvalid;
			rr = bresp;
			@(posedge ref_clk);
			if (at) awvalid <= 1'b0;
			if (wt) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic at, ok;
		ok = 1'b0;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!ok) begin
			@(negedge ref_clk);
			at = arvalid & arready;
			ok = rvalid;
			d = rdata;
			rr = rresp;
			@(posedge ref_clk);
			if (at) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask : rd

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		rd(a, rv);
		chk(nm, rv, e);
	endtask : rdchk

	task automatic wait_got(input int n);
		int k;
		k = 0;
		while (p_got < n && k < 8000) begin
			@(posedge ref_clk);
			k++;
		end
		chk("frames", 32'(p_got), 32'(n));
	endtask : wait_got

	// poll until busy drops, bounded
	task automatic wait_idle();
		int k;
		k = 0;
		rv = 32'h0000_0008;
		while (rv[3] !== 1'b0 && k < 400) begin
			rd(`UFB_OFF_FLAGS, rv);
			k++;
		end
		chk("busy drop", 32'(rv[3]), 32'h0000_0000);
	endtask : wait_idle

	task automatic t_reset();
		rdchk(`UFB_OFF_FLAGS, 32'h0000_0090, "flags");
		rdchk(`UFB_OFF_IDIV, 32'h0000_0000, "idiv");
		rd(8'h40, rv);
		chk("unmapped rd", 32'(rr), 32'h0000_0002);
		wr(8'h3c, 32'h0000_0000);
		chk("unmapped wr", 32'(rr), 32'h0000_0002);
		$display("test reset done");
	endtask : t_reset

	// divisor write alone must leave the line stalled
	task automatic t_shadow();
		wr(`UFB_OFF_IDIV, 32'hffff_ffff);
		rdchk(`UFB_OFF_IDIV, 32'h0000_ffff, "idiv field");
		wr(`UFB_OFF_IDIV, 32'h0000_0001);
		wr(`UFB_OFF_DATA, 32'h0000_003c);
		rd(`UFB_OFF_FLAGS, rv);
		chk("busy", 32'(rv[3]), 32'h0000_0001);
		repeat (100) @(posedge ref_clk);
		chk("no frame", 32'(p_got), 32'h0000_0000);
		wr(`UFB_OFF_LCH, 32'h0000_0060);
		wait_idle();
		chk("frame out", 32'(p_got), 32'h0000_0001);
		chk("byte", 32'(p_byte), 32'h0000_003c);
		$display("test shadow done");
	endtask : t_shadow

	// 2 + 32/64 clocks per tick gives a 40-clock bit
	task automatic t_frac();
		bit_clks = 16'h0028;
		wr(`UFB_OFF_IDIV, 32'h0000_0002);
		wr(`UFB_OFF_FDIV, 32'h0000_0020);
		wr(`UFB_OFF_LCH, 32'h0000_0060);
		wr(`UFB_OFF_DATA, 32'h0000_0000);
		wait_got(2);
		// nine low bits, 360 clocks; tick phase moves either end by a few
		chk("low run", 32'(p_low > 17800 && p_low < 18200), 32'h1);
		chk("byte", 32'(p_byte), 32'h0000_0000);
		bit_clks = 16'h0010;
		wr(`UFB_OFF_IDIV, 32'h0000_0001);
		wr(`UFB_OFF_FDIV, 32'h0000_0000);
		wr(`UFB_OFF_LCH, 32'h0000_0060);
		$display("test frac done");
	endtask : t_frac

	// one byte shifting, one waiting in the holding register
	task automatic t_hold();
		wr(`UFB_OFF_DATA, 32'h0000_0011);
		repeat (20) @(posedge ref_clk);
		wr(`UFB_OFF_DATA, 32'h0000_0022);
		rdchk(`UFB_OFF_FLAGS, 32'h0000_0038, "hold full");
		wait_got(4);
		wait_idle();
		rdchk(`UFB_OFF_FLAGS, 32'h0000_0090, "hold idle");
		$display("test hold done");
	endtask : t_hold

	task automatic t_txq();
		wr(`UFB_OFF_LCH, 32'h0000_0070);
		for (int i = 0; i < 17; i++)
			wr(`UFB_OFF_DATA, 32'(i));
		rdchk(`UFB_OFF_FLAGS, 32'h0000_0038, "queue full");
		wait_got(21);
		chk("last byte", 32'(p_byte), 32'h0000_0010);
		wait_idle();
		rdchk(`UFB_OFF_FLAGS, 32'h0000_0090, "queue idle");
		$display("test txq done");
	endtask : t_txq

	// receive into holding register with interrupt, then fill the queue
	task automatic t_rx();
		wr(`UFB_OFF_LCH, 32'h0000_0060);
		wr(`UFB_OFF_IMSK, 32'h0000_0000);
		rd(`UFB_OFF_IST, rv);
		u_peer.send(8'h5a);
		repeat (20) @(posedge ref_clk);
		chk("irq masked", 32'(irq), 32'h0000_0000);
		rdchk(`UFB_OFF_FLAGS, 32'h0000_00c0, "rx hold");
		wr(`UFB_OFF_IMSK, 32'h0000_0001);
		@(negedge ref_clk);
		chk("irq", 32'(irq), 32'h0000_0001);
		rdchk(`UFB_OFF_IST, 32'h0000_0001, "status");
		@(negedge ref_clk);
		chk("irq clear", 32'(irq), 32'h0000_0000);
		rdchk(`UFB_OFF_DATA, 32'h0000_005a, "rx byte");
		rdchk(`UFB_OFF_FLAGS, 32'h0000_0090, "rx empty");
		wr(`UFB_OFF_LCH, 32'h0000_0070);
		for (int i = 0; i < 16; i++)
			u_peer.send(8'h30 + 8'(i));
		repeat (20) @(posedge ref_clk);
		rdchk(`UFB_OFF_FLAGS, 32'h0000_00c0, "rxq full");
		for (int i = 0; i < 16; i++)
			rdchk(`UFB_OFF_DATA, 32'h30 + 32'(i), "rxq byte");
		rdchk(`UFB_OFF_FLAGS, 32'h0000_0090, "rxq empty");
		$display("test rx done");
	endtask : t_rx

	// main sequence
	initial begin
		reset_n = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'hf;
		bit_clks = 16'h0010;
		cyc = 0;
		num_errors = 0;
		checks = 0;
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_reset();
		t_shadow();
		t_frac();
		t_hold();
		t_txq();
		t_rx();
		close_out();
	end
endmodule : tb

// ---- dv/ufb_peer.sv ----
`timescale 1ns/10ps
// serial peer: idle-high line, lsb first, one start and one stop bit
module ufb_peer (
	input  wire logic        ref_clk,
	input  wire logic        txd,
	input  wire logic [15:0] bit_clks,
	output logic             rxd,
	output logic [7:0]       last_byte,
	output int               got,
	output int               low_ns
);
	realtime    t0;
	logic [7:0] b;

	// line rests at the pull-up level until the bench asks for a frame
	initial begin
		rxd = 1'b1;
		got = 0;
		low_ns = 0;
		last_byte = 8'h00;
	end

	// width of each low run; an all-ones byte leaves only the start bit
	always @(negedge txd) begin
		t0 = $realtime;
		@(posedge txd);
		low_ns = int'($realtime - t0);
	end

	// mid-bit sampling; frame counted just before the stop bit ends
	always begin
		@(negedge txd);
		repeat (bit_clks / 2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_clks) @(posedge ref_clk);
			b[i] = txd;
		end
		repeat (bit_clks + bit_clks / 2 - 2) @(posedge ref_clk);
		last_byte = b;
		got = got + 1;
	end

	// one frame towards the block, then back to idle high
	task automatic send(input logic [7:0] d);
		logic [9:0] fr;
		fr = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk);
			rxd <= fr[i];
			repeat (bit_clks - 1) @(posedge ref_clk);
		end
	endtask : send
endmodule : ufb_peer

// ---- hdl/ufb_baud_gen.sv ----
`timescale 1ns/10ps
`include "ufb_cfg.svh"
module ufb_baud_gen (
	input  wire logic            ref_clk,
	input  wire logic            reset_n,
	input  wire ufb_pkg::ufb_lcr_s combined_line_word,
	output logic                 tick16
);
	import ufb_pkg::*;
	logic [22:0] acc_q, acc_d, sum, div;
	logic        run, hit;

	// divisor in 1/64 units; each clock adds one whole unit of 64
	assign div  = {1'b0, combined_line_word.idiv, combined_line_word.fdiv}; // R14 R15
	assign run  = (combined_line_word.idiv != 16'h0000);
	assign sum  = acc_q + `UFB_FRAC_ONE;
	assign hit  = run && (sum >= div);
	assign acc_d = !run ? 23'h0 : (hit ? sum - div : sum);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_q  <= 23'h0;
			tick16 <= 1'b0;
		end else begin
			acc_q  <= acc_d;
			tick16 <= hit;
		end
	end

	// helper: cycles between ticks while the word stays put
	logic [16:0] gap_q;
	logic        seen_q;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			gap_q  <= 17'h0;
			seen_q <= 1'b0;
		end else begin
			gap_q  <= tick16 ? 17'h1 : gap_q + 17'h1;
			seen_q <= $stable(combined_line_word) && (seen_q || tick16);
		end
	end

	chk_tick_gap: assert property (@(posedge ref_clk) disable iff (!reset_n)
		tick16 && seen_q && $stable(combined_line_word) |->
		(gap_q >= {1'b0, combined_line_word.idiv}) && (gap_q <= {1'b0, combined_line_word.idiv} + 17'h1))
		else $error("tick spacing off divisor"); // R14
	chk_tick_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
		combined_line_word.idiv == 16'h0 |=> !tick16)
		else $error("tick with zero divisor"); // R15
endmodule : ufb_baud_gen

// ---- hdl/ufb_cfg.svh ----
`ifndef UFB_CFG_SVH
`define UFB_CFG_SVH
// register byte offsets
`define UFB_OFF_DATA   8'h00
`define UFB_OFF_FLAGS  8'h18
`define UFB_OFF_IDIV   8'h24
`define UFB_OFF_FDIV   8'h28
`define UFB_OFF_LCH    8'h2c
`define UFB_OFF_IST    8'h30
`define UFB_OFF_IMSK   8'h34
// flag register fields
`define UFB_BIT_TX_EMPTY 7
`define UFB_BIT_RX_FULL  6
`define UFB_BIT_TX_FULL  5
`define UFB_BIT_RX_EMPTY 4
`define UFB_BIT_BUSY     3
`define UFB_FLAGS_RST    5'h12
// line control high fields
`define UFB_LCH_BRK  0
`define UFB_LCH_PEN  1
`define UFB_LCH_EPS  2
`define UFB_LCH_STP2 3
`define UFB_LCH_QEN  4
`define UFB_LCH_WLO  5
`define UFB_LCH_SPS  7
// interrupt status fields
`define UFB_IST_RX   0
`define UFB_IST_TX   1
`define UFB_IST_OVR  2
// sizes and timing
`define UFB_QDEPTH   5'd16
`define UFB_QAW      4
`define UFB_FRAC_ONE 23'd64
`define UFB_OVS_LAST 4'hf
`define UFB_OVS_MID  4'h7
`define UFB_RESP_OK  2'h0
`define UFB_RESP_ERR 2'h2
`endif

// ---- hdl/ufb_pkg.sv ----
package ufb_pkg;
	// combined line control word, 30 bits
	typedef struct packed {
		logic [7:0]  lch;
		logic [15:0] idiv;
		logic [5:0]  fdiv;
	} ufb_lcr_s;
	// flag bits 7..3
	typedef struct packed {
		logic tx_empty_flag;
		logic rx_full_flag;
		logic tx_full_flag;
		logic rx_empty_flag;
		logic busy;
	} ufb_flags_s;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} ufb_rx_e;
	typedef enum logic {TX_IDLE, TX_SHIFT} ufb_tx_e;
endpackage : ufb_pkg

// ---- hdl/ufb_queue.sv ----
`timescale 1ns/10ps
`include "ufb_cfg.svh"
module ufb_queue (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       qen,
	input  wire logic       flush,
	input  wire logic       push,
	input  wire logic [7:0] wdata,
	input  wire logic       pop,
	output logic [7:0]      rdata,
	output logic            full,
	output logic            empty
);
	import ufb_pkg::*;
	logic [7:0]          mem [16];
	logic [`UFB_QAW-1:0] wp_q, rp_q;
	logic [4:0]          cnt_q;
	logic                do_push, do_pop;

	// queue disabled means a single holding register
	assign full    = qen ? (cnt_q == `UFB_QDEPTH) : (cnt_q != 5'h0);
	assign empty   = (cnt_q == 5'h0);
	assign do_push = push && !full;
	assign do_pop  = pop && !empty;
	assign rdata   = mem[rp_q];

	always_ff @(posedge ref_clk) begin
		if (do_push)
			mem[wp_q] <= wdata;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= 5'h0;
		end else if (flush) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= 5'h0;
		end else begin
			wp_q  <= wp_q + `UFB_QAW'(do_push);
			rp_q  <= rp_q + `UFB_QAW'(do_pop);
			cnt_q <= cnt_q + 5'(do_push) - 5'(do_pop);
		end
	end
endmodule : ufb_queue

// ---- hdl/ufb_top.sv ----
// How it works
// R1: reset: full and busy 0, empties 1
// R2: bit 7 transmit empty, per queue mode
// R3: bit 6 receive full, per queue mode
// R4: bit 5 transmit full, per queue mode
// R5: bit 4 receive empty, per queue mode
// R6: busy rises once transmit queue non-empty
// R7: busy holds through last stop bit
// R8: one 30-bit combined line control word
// R9: word loads only on line-control-high write
// R10: software writes divisors, then line-control-high
// R11: serial clock between 16x and 16x65535x baud
// R12: serial clock at most 5/3 system clock
// R13: integer divisor bits 15:0, reset zero
// R14: bit timing uses integer plus fraction
// R15: fraction six bits in sixty-fourths
// R16: flags follow live queue occupancy
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`include "ufb_cfg.svh"
module ufb_top (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        rxd,
	output logic             txd,
	output logic             irq
);
	import ufb_pkg::*;

	// write and read channel state
	logic [7:0]  aw_addr_q;
	logic        aw_have_q, w_have_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        wr_fire, wr_hit, ar_fire, rd_hit;
	logic        wr_data, wr_idiv, wr_fdiv, wr_lch, wr_imsk;
	logic        rd_data, rd_ist;
	logic [31:0] rd_mux;

	// software visible state
	logic [15:0] idiv_q;
	logic [5:0]  fdiv_q;
	ufb_lcr_s    lcr_q;
	logic [2:0]  ist_q, imsk_q, ist_ev;
	ufb_flags_s  flags;

	// queues and serial engines
	logic        txq_full, txq_empty, rxq_full, rxq_empty;
	logic [7:0]  txq_data, rxq_data;
	logic        tx_pop, rx_push, q_flush, tick16;
	logic        qen, pen, stp2;
	logic [1:0]  wlen;
	ufb_tx_e     tx_st_q;
	logic [11:0] tx_sh_q, tx_frame;
	logic [3:0]  tx_tk_q, tx_bits_q, tx_nbits;
	logic [7:0]  dmask, tx_dm;
	logic        tx_par, tx_done;
	logic [2:0]  tx_tail;
	ufb_rx_e     rx_st_q;
	logic [2:0]  rx_sync_q;
	logic        rx_lvl_q;
	logic [3:0]  rx_tk_q, rx_bit_q, rx_last;
	logic [9:0]  rx_sh_q;

	// address decode, word aligned
	assign wr_fire = aw_have_q && w_have_q && !bvalid;
	assign ar_fire = arvalid && arready;
	assign wr_data = aw_addr_q[7:2] == `UFB_OFF_DATA >> 2;
	assign wr_idiv = aw_addr_q[7:2] == `UFB_OFF_IDIV >> 2;
	assign wr_fdiv = aw_addr_q[7:2] == `UFB_OFF_FDIV >> 2;
	assign wr_lch  = aw_addr_q[7:2] == `UFB_OFF_LCH >> 2;
	assign wr_imsk = aw_addr_q[7:2] == `UFB_OFF_IMSK >> 2;
	assign wr_hit  = wr_data | wr_idiv | wr_fdiv | wr_lch | wr_imsk |
		(aw_addr_q[7:2] == `UFB_OFF_FLAGS >> 2) |
		(aw_addr_q[7:2] == `UFB_OFF_IST >> 2);
	assign rd_data = araddr[7:2] == `UFB_OFF_DATA >> 2;
	assign rd_ist  = araddr[7:2] == `UFB_OFF_IST >> 2;

	// handshakes are combinational, one write and one read in flight
	assign awready = !aw_have_q && !bvalid;
	assign wready  = !w_have_q && !bvalid;
	assign arready = !rvalid;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (awvalid && awready) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (wr_fire) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end else if (wvalid && wready) begin
			w_have_q <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (wr_fire) begin
			w_have_q <= 1'b0;
		end
	end

	// write response follows both halves
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bvalid <= 1'b0;
			bresp  <= `UFB_RESP_OK;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? `UFB_RESP_OK : `UFB_RESP_ERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// divisor shadows and interrupt mask; divisors do not touch timing until lch write
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			idiv_q <= 16'h0; // R13
			fdiv_q <= 6'h0;
			imsk_q <= 3'h0;
		end else if (wr_fire) begin
			if (wr_idiv && w_strb_q[0])
				idiv_q[7:0] <= w_data_q[7:0]; // R10
			if (wr_idiv && w_strb_q[1])
				idiv_q[15:8] <= w_data_q[15:8]; // R13
			if (wr_fdiv && w_strb_q[0])
				fdiv_q <= w_data_q[5:0]; // R15
			if (wr_imsk && w_strb_q[0])
				imsk_q <= w_data_q[2:0];
		end
	end

	// all 30 bits move together on a line-control-high write
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			lcr_q <= '0;
		else if (wr_fire && wr_lch && w_strb_q[0])
			lcr_q <= {w_data_q[7:0], idiv_q, fdiv_q}; // R8 R9
	end

	assign qen  = lcr_q.lch[`UFB_LCH_QEN];
	assign pen  = lcr_q.lch[`UFB_LCH_PEN];
	assign stp2 = lcr_q.lch[`UFB_LCH_STP2];
	assign wlen = lcr_q.lch[`UFB_LCH_WLO +: 2];
	// toggling queue mode empties both queues: depths disagree
	assign q_flush = wr_fire && wr_lch && w_strb_q[0] &&
		(w_data_q[`UFB_LCH_QEN] != qen);

	// flags straight from occupancy, no staging
	assign flags.tx_empty_flag = txq_empty; // R2 R16
	assign flags.rx_full_flag  = rxq_full;  // R3
	assign flags.tx_full_flag  = txq_full;  // R4
	assign flags.rx_empty_flag = rxq_empty; // R5
	assign flags.busy = !txq_empty || (tx_st_q == TX_SHIFT); // R6 R7

	always_comb begin
		rd_mux = 32'h0;
		case (araddr[7:2])
			`UFB_OFF_DATA >> 2:  rd_mux = {24'h0, rxq_data};
			`UFB_OFF_FLAGS >> 2: rd_mux = {24'h0, flags, 3'h0}; // R16
			`UFB_OFF_IDIV >> 2:  rd_mux = {16'h0, idiv_q}; // R13
			`UFB_OFF_FDIV >> 2:  rd_mux = {26'h0, fdiv_q};
			`UFB_OFF_LCH >> 2:   rd_mux = {24'h0, lcr_q.lch};
			`UFB_OFF_IST >> 2:   rd_mux = {29'h0, ist_q};
			`UFB_OFF_IMSK >> 2:  rd_mux = {29'h0, imsk_q};
			default:             rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0;
			rresp  <= `UFB_RESP_OK;
		end else if (ar_fire) begin
			rvalid <= 1'b1;
			rdata  <= rd_mux;
			rresp  <= (rd_mux == 32'h0 && araddr[7:2] > 6'hd) ?
				`UFB_RESP_ERR : `UFB_RESP_OK;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// sticky events, read clears, a fresh event wins
	assign ist_ev[`UFB_IST_RX]  = rx_push && !rxq_full;
	assign ist_ev[`UFB_IST_TX]  = tx_done;
	assign ist_ev[`UFB_IST_OVR] = rx_push && rxq_full;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			ist_q <= 3'h0;
		else
			ist_q <= (ist_q & ~{3{ar_fire && rd_ist}}) | ist_ev;
	end
	assign irq = |(ist_q & imsk_q);

	ufb_baud_gen u_baud (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.combined_line_word     (lcr_q),
		.tick16  (tick16)
	);

	ufb_queue u_txq (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.qen     (qen),
		.flush   (q_flush),
		.push    (wr_fire && wr_data && w_strb_q[0]),
		.wdata   (w_data_q[7:0]),
		.pop     (tx_pop),
		.rdata   (txq_data),
		.full    (txq_full),
		.empty   (txq_empty)
	);

	ufb_queue u_rxq (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.qen     (qen),
		.flush   (q_flush),
		.push    (rx_push),
		.wdata   (rx_sh_q[7:0] & dmask),
		.pop     (ar_fire && rd_data),
		.rdata   (rxq_data),
		.full    (rxq_full),
		.empty   (rxq_empty)
	);

	// frame: start, 5..8 data, optional parity, 1 or 2 stops
	assign dmask    = 8'hff >> (2'd3 - wlen);
	assign tx_dm    = txq_data & dmask;
	assign tx_par   = lcr_q.lch[`UFB_LCH_SPS] ? !lcr_q.lch[`UFB_LCH_EPS] :
		(^tx_dm) ^ !lcr_q.lch[`UFB_LCH_EPS];
	assign tx_tail  = pen ? {2'b11, tx_par} : 3'b111;
	assign tx_frame = 12'({9'h1ff, tx_tail} << (4'd6 + {2'b00, wlen})) |
		{3'b000, tx_dm, 1'b0};
	assign tx_nbits = 4'd7 + {2'b00, wlen} + {3'b000, pen} + {3'b000, stp2};
	// no start bit on a stalled line; busy still shows the waiting byte
	assign tx_pop   = (tx_st_q == TX_IDLE) && !txq_empty &&
		(lcr_q.idiv != 16'h0000);
	assign tx_done  = (tx_st_q == TX_SHIFT) && tick16 &&
		(tx_tk_q == `UFB_OVS_LAST) && (tx_bits_q == 4'h1);

	// busy covers the whole frame, stop bits included
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_st_q   <= TX_IDLE;
			tx_sh_q   <= 12'hfff;
			tx_tk_q   <= 4'h0;
			tx_bits_q <= 4'h0;
		end else begin
			case (tx_st_q)
				TX_IDLE: if (tx_pop) begin
					tx_st_q   <= TX_SHIFT; // R6
					tx_sh_q   <= tx_frame;
					tx_tk_q   <= 4'h0;
					tx_bits_q <= tx_nbits;
				end
				TX_SHIFT: if (tick16) begin
					tx_tk_q <= tx_tk_q + 4'h1;
					if (tx_tk_q == `UFB_OVS_LAST) begin
						tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
						tx_bits_q <= tx_bits_q - 4'h1;
						if (tx_bits_q == 4'h1)
							tx_st_q <= TX_IDLE; // R7
					end
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			txd <= 1'b1;
		else
			txd <= tx_sh_q[0] && !lcr_q.lch[`UFB_LCH_BRK];
	end

	// line input: three stages, accept once the last two agree
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_sync_q <= 3'b111;
			rx_lvl_q  <= 1'b1;
		end else begin
			rx_sync_q <= {rx_sync_q[1:0], rxd};
			if (rx_sync_q[1] == rx_sync_q[2])
				rx_lvl_q <= rx_sync_q[2];
		end
	end

	// receiver samples mid bit; stop bit is the last sample
	assign rx_last = 4'd5 + {2'b00, wlen} + {3'b000, pen};
	assign rx_push = (rx_st_q == RX_DATA) && tick16 &&
		(rx_tk_q == `UFB_OVS_LAST) && (rx_bit_q == rx_last);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_st_q  <= RX_IDLE;
			rx_tk_q  <= 4'h0;
			rx_bit_q <= 4'h0;
			rx_sh_q  <= 10'h0;
		end else begin
			case (rx_st_q)
				RX_IDLE: if (!rx_lvl_q) begin
					rx_st_q <= RX_START;
					rx_tk_q <= 4'h0;
				end
				RX_START: if (tick16) begin
					rx_tk_q <= rx_tk_q + 4'h1;
					if (rx_tk_q == `UFB_OVS_MID) begin
						rx_st_q  <= rx_lvl_q ? RX_IDLE : RX_DATA;
						rx_tk_q  <= 4'h0;
						rx_bit_q <= 4'h0;
					end
				end
				RX_DATA: if (tick16) begin
					rx_tk_q <= rx_tk_q + 4'h1;
					if (rx_tk_q == `UFB_OVS_LAST) begin
						rx_sh_q[rx_bit_q] <= rx_lvl_q;
						rx_bit_q <= rx_bit_q + 4'h1;
						if (rx_bit_q == rx_last)
							rx_st_q <= RX_IDLE;
					end
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	sequence s_lch_write;
		wr_fire && wr_lch && w_strb_q[0];
	endsequence

	chk_reset_flags: assert property (@(posedge ref_clk)
		$rose(reset_n) |-> flags == `UFB_FLAGS_RST)
		else $error("flags wrong after reset"); // R1
	chk_hold_full: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!qen && txq_empty && wr_fire && wr_data && w_strb_q[0] && !tx_pop
		|=> flags.tx_full_flag || !flags.tx_empty_flag)
		else $error("holding register flag wrong"); // R2 R4
	chk_busy_rise: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$fell(txq_empty) |-> flags.busy)
		else $error("busy late"); // R6
	chk_busy_frame: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$fell(flags.busy) |-> $past(tx_done) &&
		(txd || lcr_q.lch[`UFB_LCH_BRK]))
		else $error("busy dropped mid frame"); // R7
	chk_lcr_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_lch_write |=> lcr_q == {$past(w_data_q[7:0]), $past(idiv_q),
		$past(fdiv_q)})
		else $error("combined word not loaded"); // R8 R9
	chk_div_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!(wr_fire && wr_lch) |=> $stable(lcr_q))
		else $error("combined word moved without lch write"); // R9
	chk_idiv_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ar_fire && araddr[7:2] == `UFB_OFF_IDIV >> 2 |=>
		rdata == {16'h0, $past(idiv_q)})
		else $error("integer divisor readback wrong"); // R13
	chk_flag_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ar_fire && araddr[7:2] == `UFB_OFF_FLAGS >> 2 |=>
		rdata[7:3] == $past(flags) && rdata[31:8] == 24'h0 &&
		rdata[2:0] == 3'h0)
		else $error("flag read stale"); // R16 R3 R5
endmodule : ufb_top
